// file: rtl/pbi_params.svh
// Summary of operation
// - Master drives 32-bit byte address per transfer
// - At most 32 data bits; size+A1:A0 lanes
// - Two-bit transfer type classifies four kinds
// - Line number driven on push/load transfers
// - User attributes follow matching translation entry
// - Attributes only for normal/block move, else zero
// - Translation off means attributes zero
// - Attributes high impedance when not master
// - Direction high read, low write
// - Snooper samples direction and size from others
// - Lock asserted on locked sequence transfers
// - Release bus on grant loss despite lock
// - Lock drives negated high before release
// - Lock-end on last locked; undriven when idle
// - Start pulse, in-progress held whole transfer
// - Slave ends transfer with ack or error
// - Slave asserts burst or cache inhibit inputs
// - Cache-inhibit out on uncached transfers
// - Request, grant, busy asserted once owner
// - Snoop select input; memory hold-off while snooping
// - Reset-out only during reset instruction
// - Encoded irq level, pending flag, autovector
`ifndef PBI_PARAMS_SVH
`define PBI_PARAMS_SVH
`define PBI_TT_NORMAL   2'h0
`define PBI_TT_BLKMOVE  2'h1
`define PBI_TT_ALTFC    2'h2
`define PBI_TT_ACK      2'h3
`define PBI_SZ_LONG     2'h0
`define PBI_SZ_BYTE     2'h1
`define PBI_SZ_WORD     2'h2
`define PBI_SZ_LINE     2'h3
`define PBI_SNOOP_OFF   2'h0
`define PBI_SLAVE_WAIT  4'h2
`define PBI_MEM_FILL    32'h00000000
`endif

// file: rtl/pbi_pkg.sv
`default_nettype none
package pbi_pkg;
  typedef enum logic [1:0] {
    PBI_M_IDLE  = 2'b00,
    PBI_M_OWN   = 2'b01,
    PBI_M_XFER  = 2'b11,
    PBI_M_PARK  = 2'b10
  } pbi_mst_e;
  typedef enum logic [1:0] {
    PBI_S_IDLE  = 2'b00,
    PBI_S_WAIT  = 2'b01,
    PBI_S_DONE  = 2'b11
  } pbi_slv_e;
endpackage
`default_nettype wire

// file: rtl/pbi_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pbi_bus_if;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0]  xfer_type;
  logic [2:0]  xfer_modifier;
  logic [1:0]  line_slot_number;
  logic [1:0]  user_attr_out;
  logic        user_attr_oe;
  logic        rw_o;
  logic        rw_oe;
  logic        rw_i;
  logic [1:0]  size_o;
  logic        size_oe;
  logic [1:0]  size_i;
  logic        lock_n;
  logic        lock_oe;
  logic        rmw_last_n;
  logic        rmw_last_oe;
  logic        nocache_out_n;
  logic        xfer_begin_n;
  logic        xfer_in_progress_n;
  logic        xfer_ack_n;
  logic        xfer_error_ack_n;
  logic        slave_nocache_n;
  logic        burst_inhibit_n;
  logic [1:0]  snoop_select;
  logic        memory_hold_off_n;
  logic        bus_request_n;
  logic        bus_grant_n;
  logic        bus_busy_n;
  logic        reset_out_n;
  logic [2:0]  irq_level_n;
  logic        irq_pending_n;
  logic        auto_vector_req_n;
  modport dev (
    output addr, wdata, xfer_type, xfer_modifier, line_slot_number, user_attr_out,
           user_attr_oe, rw_o, rw_oe, size_o, size_oe, lock_n, lock_oe, rmw_last_n,
           rmw_last_oe, nocache_out_n, xfer_begin_n, xfer_in_progress_n,
           memory_hold_off_n, bus_request_n, bus_busy_n, reset_out_n, irq_pending_n,
    input  rdata, rw_i, size_i, xfer_ack_n, xfer_error_ack_n, slave_nocache_n,
           burst_inhibit_n, snoop_select, bus_grant_n, irq_level_n, auto_vector_req_n
  );
  modport sys (
    input  addr, wdata, xfer_type, xfer_modifier, line_slot_number, user_attr_out,
           user_attr_oe, rw_o, rw_oe, size_o, size_oe, lock_n, lock_oe, rmw_last_n,
           rmw_last_oe, nocache_out_n, xfer_begin_n, xfer_in_progress_n,
           memory_hold_off_n, bus_request_n, bus_busy_n, reset_out_n, irq_pending_n,
    output rdata, rw_i, size_i, xfer_ack_n, xfer_error_ack_n, slave_nocache_n,
           burst_inhibit_n, snoop_select, bus_grant_n, irq_level_n, auto_vector_req_n
  );
endinterface
`default_nettype wire

// file: rtl/pbi_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbi_params.svh"
module pbi_master
  import pbi_pkg::*;
(
  input  wire logic        i_ref_clk,       // Bus clock
  input  wire logic        i_rst_n,         // Processor reset in
  pbi_bus_if.dev           bus,             // External bus
  input  wire logic        i_req,           // Core transfer request
  input  wire logic [31:0] i_addr,          // Transfer address
  input  wire logic [31:0] i_wdata,         // Write data
  input  wire logic        i_read,          // 1 read, 0 write
  input  wire logic [1:0]  i_size,          // Transfer size code
  input  wire logic [1:0]  i_type,          // Transfer type
  input  wire logic [2:0]  i_modifier,      // Transfer modifier
  input  wire logic [1:0]  i_line_slot,     // Line slot of push/load
  input  wire logic        i_line_xfer,     // Push or load transfer
  input  wire logic [1:0]  i_attr,          // Matching entry attributes
  input  wire logic        i_xlate_on,      // TTR or MMU enabled
  input  wire logic        i_attr_access,   // Normal code/data/block move
  input  wire logic        i_nocache,       // Uncached access
  input  wire logic        i_locked,        // Part of locked sequence
  input  wire logic        i_lock_last,     // Last of locked sequence
  input  wire logic        i_reset_instr,   // Reset instruction executing
  input  wire logic        i_irq_pend,      // Core sees pending irq
  output logic             o_ready,         // Request accepted
  output logic             o_done,          // Transfer ended pulse
  output logic             o_error,         // Ended with error
  output logic [31:0]      o_rdata,         // Read data
  output logic [2:0]       o_irq_level,     // Encoded irq level
  output logic             o_autovec,       // Autovector on last ack
  output logic             o_snoop_hit,     // Snooped access seen
  output logic             o_snoop_rw,      // Snooped direction
  output logic [1:0]       o_snoop_size,    // Snooped size
  output logic             o_slave_nocache, // Slave inhibited caching
  output logic             o_burst_inh      // Slave inhibited burst
);
  // ==========================================================
  // Whole state of the master, one packed word
  typedef struct packed {
    pbi_mst_e    st;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  ttype;
    logic [2:0]  tmod;
    logic [1:0]  tln;
    logic [1:0]  upa;
    logic        rw;
    logic [1:0]  siz;
    logic        lock;
    logic        lock_hi;
    logic        rmw_last;
    logic        ci;
    logic        ts;
    logic        xfer_in_progress;
    logic        busy;
    logic        req;
    logic        done;
    logic        err;
    logic        auto_vector_req;
    logic        mi;
    logic        snp;
    logic        snp_rw;
    logic [1:0]  snp_siz;
    logic        slave_nocache;
    logic        burst_inhibit;
    logic        reset_out;
    logic [2:0]  ipl;
    logic        irq_pending;
  } pbi_mst_s;
  pbi_mst_s s_reg;
  pbi_mst_s s_next;
  logic     granted;
  logic     ended;
  // Grant seen and transfer answered
  assign granted = ~bus.bus_grant_n;
  assign ended   = ~bus.xfer_ack_n | ~bus.xfer_error_ack_n;
  // ==========================================================
  // Next state of the whole master
  always_comb begin
    s_next      = s_reg;
    s_next.ts   = 1'b0;
    s_next.done = 1'b0;
    s_next.reset_out = i_reset_instr;
    s_next.ipl  = ~bus.irq_level_n;
    s_next.irq_pending = i_irq_pend;
    s_next.snp  = 1'b0;
    s_next.mi   = 1'b0;
    // Snoop only while another master owns the bus
    if (s_reg.st == PBI_M_IDLE && bus.bus_busy_n == 1'b1 &&
        bus.snoop_select != `PBI_SNOOP_OFF) begin
      s_next.snp     = 1'b1;
      s_next.snp_rw  = bus.rw_i;
      s_next.snp_siz = bus.size_i;
      s_next.mi      = 1'b1;
    end
    unique case (s_reg.st)
      PBI_M_IDLE: begin
        s_next.req = i_req | s_reg.rmw_last;
        if (i_req && granted) begin
          s_next.st   = PBI_M_OWN;
          s_next.busy = 1'b1;
        end
      end
      PBI_M_OWN: begin
        s_next.lock_hi = 1'b0;
        // Grant lost between transfers: park one cycle with lock high
        if (!granted && !s_reg.xfer_in_progress) begin
          s_next.st      = PBI_M_PARK;
          s_next.lock    = 1'b0;
          s_next.lock_hi = 1'b1;
        end else if (i_req) begin
          s_next.st    = PBI_M_XFER;
          s_next.addr  = i_addr;
          s_next.wdata = i_wdata;
          s_next.rw    = i_read;
          s_next.siz   = i_size;
          s_next.ttype = i_type;
          s_next.tmod  = i_modifier;
          s_next.tln   = i_line_xfer ? i_line_slot : 2'h0;
          s_next.upa   = (i_xlate_on && i_attr_access) ? i_attr : 2'h0;
          s_next.ci    = i_nocache;
          s_next.lock  = i_locked;
          s_next.rmw_last = i_lock_last;
          s_next.ts    = 1'b1;
          s_next.xfer_in_progress   = 1'b1;
          s_next.req   = 1'b0;
        end else begin
          s_next.req = 1'b0;
        end
      end
      PBI_M_XFER: begin
        // A started transfer always runs to its answer, grant or not
        if (ended) begin
          s_next.st    = PBI_M_OWN;
          s_next.xfer_in_progress   = 1'b0;
          s_next.done  = 1'b1;
          s_next.err   = ~bus.xfer_error_ack_n;
          s_next.auto_vector_req  = ~bus.auto_vector_req_n & (s_reg.ttype == `PBI_TT_ACK);
          s_next.rdata = bus.rdata;
          s_next.slave_nocache   = ~bus.slave_nocache_n;
          s_next.burst_inhibit   = ~bus.burst_inhibit_n;
          s_next.rmw_last = 1'b0;
        end
      end
      PBI_M_PARK: begin
        // Lock was driven high this cycle; now every owned pin lets go
        s_next.st      = PBI_M_IDLE;
        s_next.busy    = 1'b0;
        s_next.lock_hi = 1'b0;
        s_next.upa     = 2'h0;
      end
    endcase
  end
  // ==========================================================
  // State register on bus clock rising edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  // ==========================================================
  // Bus drive; owned outputs undriven when not master
  logic owner;
  assign owner                  = (s_reg.st == PBI_M_OWN) || (s_reg.st == PBI_M_XFER);
  assign bus.addr               = s_reg.addr;
  assign bus.wdata              = s_reg.wdata;
  assign bus.xfer_type          = s_reg.ttype;
  assign bus.xfer_modifier      = s_reg.tmod;
  assign bus.line_slot_number   = s_reg.tln;
  assign bus.user_attr_out      = s_reg.upa;
  assign bus.user_attr_oe       = owner;
  assign bus.rw_o               = s_reg.rw;
  assign bus.rw_oe              = owner;
  assign bus.size_o             = s_reg.siz;
  assign bus.size_oe            = owner;
  assign bus.lock_n             = ~(s_reg.lock & owner);
  assign bus.lock_oe            = owner | s_reg.lock_hi;
  assign bus.rmw_last_n         = ~s_reg.rmw_last;
  assign bus.rmw_last_oe        = owner;
  assign bus.nocache_out_n      = ~s_reg.ci;
  assign bus.xfer_begin_n       = ~s_reg.ts;
  assign bus.xfer_in_progress_n = ~s_reg.xfer_in_progress;
  assign bus.memory_hold_off_n  = ~s_reg.mi;
  assign bus.bus_request_n      = ~(s_reg.req | i_req);
  assign bus.bus_busy_n         = ~s_reg.busy;
  assign bus.reset_out_n        = ~s_reg.reset_out;
  assign bus.irq_pending_n      = ~s_reg.irq_pending;
  // ==========================================================
  // Core-side results
  assign o_ready         = (s_reg.st == PBI_M_OWN) && granted && i_req;
  assign o_done          = s_reg.done;
  assign o_error         = s_reg.err;
  assign o_rdata         = s_reg.rdata;
  assign o_irq_level     = s_reg.ipl;
  assign o_autovec       = s_reg.auto_vector_req;
  assign o_snoop_hit     = s_reg.snp;
  assign o_snoop_rw      = s_reg.snp_rw;
  assign o_snoop_size    = s_reg.snp_siz;
  assign o_slave_nocache = s_reg.slave_nocache;
  assign o_burst_inh     = s_reg.burst_inhibit;
endmodule
`default_nettype wire

// file: rtl/pbi_system.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbi_params.svh"
module pbi_system
  import pbi_pkg::*;
#(
  parameter int DEPTH = 16                  // Memory words
) (
  input  wire logic        i_ref_clk,       // Bus clock
  input  wire logic        i_rst_n,         // System reset
  pbi_bus_if.sys           bus,             // External bus
  input  wire logic        i_grant,         // Arbiter grants processor
  input  wire logic        i_err_inject,    // Answer with error ack
  input  wire logic        i_nocache,       // Region is uncachable
  input  wire logic        i_no_burst,      // Region cannot burst
  input  wire logic [1:0]  i_snoop_sel,     // Snoop op for alt master
  input  wire logic        i_alt_rw,        // Alternate master direction
  input  wire logic [1:0]  i_alt_size,      // Alternate master size
  input  wire logic [2:0]  i_irq_level,     // Encoded irq level
  input  wire logic        i_autovec,       // Answer acks with autovector
  output logic             o_rmw_locked,    // Processor holds lock
  output logic             o_seen_write     // Write taken pulse
);
  // Refuse depths that the word index cannot address
  if (DEPTH < 2 || DEPTH > 1024 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 1024");
  end
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    pbi_slv_e    st;
    logic [3:0]  cnt;
    logic [31:0] rdata;
    logic        ack;
    logic        wr;
  } pbi_sys_s;
  pbi_sys_s    s_reg;
  pbi_sys_s    s_next;
  logic [31:0] mem [DEPTH];
  logic [AW-1:0] widx;
  logic [3:0]  lanes;
  assign widx = bus.addr[AW+1:2];
  // Byte lanes from size and low address bits
  always_comb begin
    lanes = 4'hf;
    unique case (bus.size_o)
      `PBI_SZ_BYTE: lanes = 4'h8 >> bus.addr[1:0];
      `PBI_SZ_WORD: lanes = bus.addr[1] ? 4'h3 : 4'hc;
      default:      lanes = 4'hf;
    endcase
  end
  // Slave answer sequencing
  always_comb begin
    s_next     = s_reg;
    s_next.ack = 1'b0;
    s_next.wr  = 1'b0;
    unique case (s_reg.st)
      PBI_S_IDLE: begin
        if (!bus.xfer_begin_n) begin
          s_next.st  = PBI_S_WAIT;
          s_next.cnt = `PBI_SLAVE_WAIT;
        end
      end
      PBI_S_WAIT: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          s_next.st    = PBI_S_DONE;
          s_next.ack   = 1'b1;
          s_next.rdata = mem[widx];
          s_next.wr    = ~bus.rw_o;
        end
      end
      PBI_S_DONE: s_next.st = PBI_S_IDLE;
      default:    s_next.st = PBI_S_IDLE;
    endcase
  end
  // Sequencer and memory on bus clock
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (s_next.wr && lanes[b]) begin
        mem[widx][b*8 +: 8] <= bus.wdata[b*8 +: 8];
      end
    end
  end
  // Answers toward the processor
  logic alt_own;
  assign alt_own               = bus.bus_busy_n & ~i_grant;
  assign bus.rdata             = s_reg.rdata;
  assign bus.xfer_ack_n        = ~(s_reg.ack & ~i_err_inject);
  assign bus.xfer_error_ack_n  = ~(s_reg.ack & i_err_inject);
  assign bus.slave_nocache_n   = ~(s_reg.ack & i_nocache);
  assign bus.burst_inhibit_n   = ~(s_reg.ack & i_no_burst);
  assign bus.auto_vector_req_n = ~(s_reg.ack & i_autovec &
                                   (bus.xfer_type == `PBI_TT_ACK));
  assign bus.bus_grant_n       = ~i_grant;
  assign bus.snoop_select      = alt_own ? i_snoop_sel : 2'h0;
  assign bus.rw_i              = bus.rw_oe ? bus.rw_o : i_alt_rw;
  assign bus.size_i            = bus.size_oe ? bus.size_o : i_alt_size;
  assign bus.irq_level_n       = ~i_irq_level;
  assign o_rmw_locked          = bus.lock_oe & ~bus.lock_n;
  assign o_seen_write          = s_reg.wr;
endmodule
`default_nettype wire

// file: tb/pbi_bus_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bus protocol checker
module pbi_bus_props (
  input wire logic       i_ref_clk,            // Bus clock
  input wire logic       i_rst_n,              // Async reset
  input wire logic       i_xfer_begin_n,       // Start strobe
  input wire logic       i_xfer_in_progress_n, // Transfer running
  input wire logic       i_xfer_ack_n,         // Slave ack
  input wire logic       i_xfer_error_ack_n,   // Slave error ack
  input wire logic       i_bus_busy_n,         // Ownership
  input wire logic       i_bus_grant_n,        // Arbiter grant
  input wire logic       i_bus_request_n,      // Master request
  input wire logic       i_user_attr_oe,       // Attribute drive
  input wire logic       i_rmw_last_oe,        // Lock-end drive
  input wire logic       i_lock_n,             // Lock level
  input wire logic       i_lock_oe,            // Lock drive
  input wire logic       i_rw_oe,              // Direction drive
  input wire logic       i_memory_hold_off_n,  // Memory hold-off
  input wire logic [1:0] i_snoop_select        // Snoop op
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Transfer framing
  a_begin_one_cycle: assert property ($fell(i_xfer_begin_n) |=> i_xfer_begin_n)
    else $error("start strobe longer than one cycle");
  a_tip_at_begin: assert property (!i_xfer_begin_n |-> !i_xfer_in_progress_n)
    else $error("start without in-progress");
  a_ack_after_wait: assert property (
    $fell(i_xfer_begin_n) |-> ##3 (!i_xfer_ack_n || !i_xfer_error_ack_n))
    else $error("slave answer not three cycles after start");
  a_ack_ends_tip: assert property (
    (!i_xfer_ack_n || !i_xfer_error_ack_n) |-> !i_xfer_in_progress_n ##1 i_xfer_in_progress_n)
    else $error("in-progress not ended after answer");
  a_rw_driven: assert property (!i_xfer_begin_n |-> i_rw_oe)
    else $error("direction not driven during transfer");
  // ==========================================================
  // Ownership and release
  a_busy_after_grant: assert property (
    $fell(i_bus_busy_n) |-> !$past(i_bus_grant_n) && !$past(i_bus_request_n))
    else $error("ownership taken without request and grant");
  a_begin_when_owned: assert property (!i_xfer_begin_n |-> !i_bus_busy_n)
    else $error("start while not owner");
  a_idle_no_drive: assert property (
    i_bus_busy_n && $past(i_bus_busy_n) |-> !i_user_attr_oe && !i_rmw_last_oe)
    else $error("attribute or lock-end driven while not owner");
  a_lock_high_off: assert property ($fell(i_lock_oe) |-> $past(i_lock_n))
    else $error("lock released without driving high");
  a_holdoff_snoop: assert property (
    $fell(i_memory_hold_off_n) |-> i_bus_busy_n && $past(i_snoop_select) != 2'h0)
    else $error("memory hold-off without snoop");
  // ==========================================================
  // Main scenarios reached
  c_ack: cover property (!i_xfer_ack_n);
  c_error: cover property (!i_xfer_error_ack_n);
  c_release: cover property ($fell(i_lock_oe));
  c_snoop: cover property ($fell(i_memory_hold_off_n));
endmodule
`default_nettype wire

// file: tb/processor_bus_signal_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbi_params.svh"
// ==========================================================
// Bench for master and system ends
module processor_bus_signal_interface_tb;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        req = 1'b0, rd = 1'b0, line_x = 1'b0, xlate = 1'b0, acc = 1'b0, nc = 1'b0;
  logic        lck = 1'b0, lck_last = 1'b0, rst_ins = 1'b0, irqp = 1'b0, grant = 1'b0;
  logic        err = 1'b0, snc = 1'b0, nob = 1'b0, arw = 1'b0, av = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0;
  logic [1:0]  size = 2'h0, typ = 2'h0, slot = 2'h0, attr = 2'h0, ssel = 2'h0, asz = 2'h0;
  logic [2:0]  ipl = 3'h0;
  logic        rdy, done, erro, autov, shit, srw, snco, bio, s_rw, s_ci, s_lock, s_last;
  logic        seen_wr, rmw_lk, s_wr;
  logic [31:0] rdata, s_addr;
  logic [2:0]  lvl;
  logic [1:0]  ssz, s_type, s_upa, s_slot;
  int          fail_count = 0;
  int          checked = 0;
  // Bus clock
  always #5 i_ref_clk = ~i_ref_clk;
  // ==========================================================
  // Both ends joined by the interface
  pbi_bus_if bus ();
  pbi_master pbi_master_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus.dev), .i_req(req), .i_addr(addr),
    .i_wdata(wdata), .i_read(rd), .i_size(size), .i_type(typ), .i_modifier(3'h0),
    .i_line_slot(slot), .i_line_xfer(line_x), .i_attr(attr), .i_xlate_on(xlate),
    .i_attr_access(acc), .i_nocache(nc), .i_locked(lck), .i_lock_last(lck_last),
    .i_reset_instr(rst_ins), .i_irq_pend(irqp), .o_ready(rdy), .o_done(done),
    .o_error(erro), .o_rdata(rdata), .o_irq_level(lvl), .o_autovec(autov),
    .o_snoop_hit(shit), .o_snoop_rw(srw), .o_snoop_size(ssz), .o_slave_nocache(snco),
    .o_burst_inh(bio));
  pbi_system #(.DEPTH(16)) pbi_system_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus.sys), .i_grant(grant),
    .i_err_inject(err), .i_nocache(snc), .i_no_burst(nob), .i_snoop_sel(ssel),
    .i_alt_rw(arw), .i_alt_size(asz), .i_irq_level(ipl), .i_autovec(av),
    .o_rmw_locked(rmw_lk), .o_seen_write(seen_wr));
  pbi_bus_props pbi_bus_props_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_xfer_begin_n(bus.xfer_begin_n),
    .i_xfer_in_progress_n(bus.xfer_in_progress_n), .i_xfer_ack_n(bus.xfer_ack_n),
    .i_xfer_error_ack_n(bus.xfer_error_ack_n), .i_bus_busy_n(bus.bus_busy_n),
    .i_bus_grant_n(bus.bus_grant_n), .i_bus_request_n(bus.bus_request_n),
    .i_user_attr_oe(bus.user_attr_oe), .i_rmw_last_oe(bus.rmw_last_oe),
    .i_lock_n(bus.lock_n), .i_lock_oe(bus.lock_oe), .i_rw_oe(bus.rw_oe),
    .i_memory_hold_off_n(bus.memory_hold_off_n), .i_snoop_select(bus.snoop_select));
  // ==========================================================
  // Compare, verdict and transfer helpers
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout(input string nm);
    fail_count++;
    $display("ERROR %s expected handshake seen timeout", nm);
    print_verdict();
  endtask
  // One whole transfer; bus qualifiers captured in the start cycle
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic r,
                      input logic [1:0] t);
    int n;
    addr = a;
    wdata = d;
    rd = r;
    typ = t;
    s_wr = 1'b0;
    req = 1'b1;
    #1;
    for (n = 0; n < 40 && rdy !== 1'b1; n++) @(posedge i_ref_clk) #1;
    if (n >= 40) timeout("ready");
    @(posedge i_ref_clk) #1;
    req = 1'b0;
    for (n = 0; n < 40 && done !== 1'b1; n++) begin
      if (seen_wr === 1'b1) s_wr = 1'b1;
      if (bus.xfer_begin_n === 1'b0)
        {s_addr, s_rw, s_type, s_upa, s_slot, s_ci, s_lock, s_last} = {bus.addr,
          bus.rw_o, bus.xfer_type, bus.user_attr_out, bus.line_slot_number,
          bus.nocache_out_n, bus.lock_n, bus.rmw_last_n};
      @(posedge i_ref_clk) #1;
    end
    if (n >= 40) timeout("done");
  endtask
  // ==========================================================
  // Scenarios
  task automatic sc_write_read();
    xfer(32'h00000008, 32'hcafef00d, 1'b0, `PBI_TT_NORMAL);
    chk_bit("rw write", 1'b0, s_rw);
    chk_bit("write seen", 1'b1, s_wr);
    xfer(32'h00000008, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_bit("rw read", 1'b1, s_rw);
    chk_bit("read no write", 1'b0, s_wr);
    chk_word("read data", 32'hcafef00d, rdata);
    chk_bit("no error", 1'b0, erro);
    xfer(32'hfffffffc, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_word("address", 32'hfffffffc, s_addr);
  endtask
  task automatic sc_types();
    av = 1'b1;
    for (int t = 0; t < 4; t++) begin
      xfer(32'h00000010, 32'h0, 1'b1, 2'(t));
      chk_word("xfer type", 32'(t), {30'h0, s_type});
      chk_bit("autovector", t == 3, autov);
    end
    av = 1'b0;
  endtask
  task automatic sc_attr();
    attr = 2'h2;
    slot = 2'h3;
    for (int k = 0; k < 4; k++) begin
      {xlate, acc} = 2'(3 - k);
      line_x = k[0];
      nc = k[1];
      xfer(32'h00000020, 32'h0, 1'b1, `PBI_TT_NORMAL);
      chk_word("user attr", (k == 0) ? 32'h2 : 32'h0, {30'h0, s_upa});
      chk_word("line slot", k[0] ? 32'h3 : 32'h0, {30'h0, s_slot});
      chk_bit("nocache out", ~k[1], s_ci);
    end
    {xlate, acc, line_x, nc} = 4'h0;
  endtask
  task automatic sc_error();
    {err, snc, nob} = 3'h7;
    xfer(32'h00000004, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_bit("error flag", 1'b1, erro);
    chk_bit("slave nocache", 1'b1, snco);
    chk_bit("burst inhibit", 1'b1, bio);
    {err, snc, nob} = 3'h0;
    xfer(32'h00000004, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_bit("error cleared", 1'b0, erro);
    chk_bit("slave cacheable", 1'b0, snco);
  endtask
  task automatic sc_lock();
    int n;
    lck = 1'b1;
    xfer(32'h00000008, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_bit("lock read", 1'b0, s_lock);
    chk_bit("not last", 1'b1, s_last);
    chk_bit("rmw locked", 1'b1, rmw_lk);
    lck_last = 1'b1;
    xfer(32'h00000008, 32'hcafef00d, 1'b0, `PBI_TT_NORMAL);
    chk_bit("lock write", 1'b0, s_lock);
    chk_bit("last of lock", 1'b0, s_last);
    {lck, lck_last, grant} = 3'h0;
    for (n = 0; n < 20 && bus.bus_busy_n !== 1'b1; n++) @(posedge i_ref_clk) #1;
    if (n >= 20) timeout("release");
    repeat (2) @(posedge i_ref_clk) #1;
    chk_bit("lock undriven", 1'b0, bus.lock_oe);
    chk_bit("rmw unlocked", 1'b0, rmw_lk);
  endtask
  task automatic sc_snoop();
    int n;
    for (int k = 0; k < 2; k++) begin
      arw = ~k[0];
      asz = k[0] ? `PBI_SZ_BYTE : `PBI_SZ_WORD;
      ssel = 2'(k + 1);
      for (n = 0; n < 20 && shit !== 1'b1; n++) @(posedge i_ref_clk) #1;
      if (n >= 20) timeout("snoop");
      chk_bit("snoop rw", ~k[0], srw);
      chk_word("snoop size", {30'h0, asz}, {30'h0, ssz});
      chk_bit("memory hold-off", 1'b0, bus.memory_hold_off_n);
      ssel = 2'h0;
      repeat (3) @(posedge i_ref_clk) #1;
    end
    grant = 1'b1;
    xfer(32'h00000008, 32'h0, 1'b1, `PBI_TT_NORMAL);
    chk_word("data after regrant", 32'hcafef00d, rdata);
  endtask
  task automatic sc_misc();
    int n;
    {rst_ins, irqp, ipl} = {2'h3, 3'h5};
    @(posedge i_ref_clk) #1;
    chk_bit("reset out on", 1'b0, bus.reset_out_n);
    chk_bit("irq pending", 1'b0, bus.irq_pending_n);
    for (n = 0; n < 8 && lvl !== 3'h5; n++) @(posedge i_ref_clk) #1;
    chk_word("irq level", 32'h5, {29'h0, lvl});
    {rst_ins, irqp} = 2'h0;
    @(posedge i_ref_clk) #1;
    chk_bit("reset out off", 1'b1, bus.reset_out_n);
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (8) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    grant = 1'b1;
    chk_bit("idle busy", 1'b1, bus.bus_busy_n);
    chk_bit("idle attr drive", 1'b0, bus.user_attr_oe);
    sc_write_read();
    sc_types();
    sc_attr();
    sc_error();
    sc_misc();
    sc_lock();
    sc_snoop();
    print_verdict();
  end
endmodule
`default_nettype wire
